//--- ilcb_pkg.sv
package ilcb_pkg;
	// Register map, byte address on the APB side.
	localparam logic [7:0] ILCB_BUS_CONTROL_TWO_ADDR = 8'h00;
	localparam logic [7:0] ILCB_SCL_CONTROL_ADDR = 8'h04;
	// Field positions inside bus_control_two.
	localparam int ILCB_SDA_LEVEL_BIT = 5;
	localparam int ILCB_SDA_GUARD_BIT = 4;
	localparam int ILCB_SCL_MON_BIT = 3;
	localparam int ILCB_RSVD2_BIT = 2;
	localparam int ILCB_PART_RST_BIT = 1;
	localparam int ILCB_RSVD0_BIT = 0;
	// Reset values.
	localparam logic ILCB_SDA_LEVEL_RST = 1'h1;
	localparam logic ILCB_PART_RST_RST = 1'h0;
	localparam logic ILCB_SCL_REQ_RST = 1'h1;
	// Divider of the sample bus clock produced by the control logic.
	localparam logic [7:0] ILCB_SCL_HALF_PERIOD = 8'h31;

	// State of the bus control logic.
	typedef enum logic [1:0] {
		ILCB_IDLE = 2'b00,
		ILCB_RUN = 2'b01,
		ILCB_HELD = 2'b11
	} ilcb_state_type;

	// Two-signal view of one open-drain pin.
	typedef struct packed {
		logic out;
		logic oe;
	} ilcb_pin_type;

	// APB request from the master.
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} ilcb_apb_req_type;
endpackage : ilcb_pkg

//--- ilcb_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Bus control logic kept in reset by the part reset bit; it toggles SCL when enabled.
module ilcb_ctrl (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic part_rst_i,
	input wire logic scl_run_i,
	output logic scl_level_o,
	output ilcb_pkg::ilcb_state_type state_o
);
	import ilcb_pkg::*;

	logic [7:0] count;
	logic scl_level;
	ilcb_state_type state;
	ilcb_state_type next_state;
	logic tick;

	// Next state, with the part reset taking priority.
	assign tick = (count == ILCB_SCL_HALF_PERIOD);
	always_comb begin
		next_state = state;
		unique case (state)
			ILCB_IDLE: if (scl_run_i) next_state = ILCB_RUN;
			ILCB_RUN: if (!scl_run_i) next_state = ILCB_IDLE;
			ILCB_HELD: next_state = ILCB_IDLE;
		endcase
		if (part_rst_i) next_state = ILCB_HELD;
	end

	// State, divider and SCL level; during part reset divider and SCL level hold their reset values and state goes to ILCB_HELD.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= ILCB_IDLE;
			count <= 8'h00;
			scl_level <= ILCB_SCL_REQ_RST;
		end else begin
			state <= next_state;
			if (part_rst_i || state != ILCB_RUN) begin
				count <= 8'h00;
				scl_level <= ILCB_SCL_REQ_RST;
			end else begin
				count <= tick ? 8'h00 : count + 8'h01;
				if (tick) scl_level <= ~scl_level;
			end
		end
	end

	assign scl_level_o = scl_level;
	assign state_o = state;
endmodule : ilcb_ctrl
`default_nettype wire

//--- ilcb_line_ctrl.sv
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ilcb_line_ctrl (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o
);
	import ilcb_pkg::*;

	logic sda_level;
	logic part_rst;
	logic scl_run;
	logic scl_level;
	logic [31:0] prdata;
	logic pslverr;
	ilcb_state_type ctrl_state;
	ilcb_pin_type sda_pin;
	ilcb_pin_type scl_pin;
	logic acc;
	logic wr_acc;
	logic rd_acc;
	logic hit_bc2;
	logic hit_scl;
	logic sda_wr_ok;
	logic [7:0] bc2_view;
	logic [31:0] next_prdata;

	// Access decode; the slave answers in the first access cycle, data latched in setup.
	assign acc = psel_i && penable_i;
	assign wr_acc = acc && pwrite_i;
	assign rd_acc = acc && !pwrite_i;
	assign hit_bc2 = (paddr_i == ILCB_BUS_CONTROL_TWO_ADDR);
	assign hit_scl = (paddr_i == ILCB_SCL_CONTROL_ADDR);
	assign sda_wr_ok = wr_acc && hit_bc2 && !pwdata_i[ILCB_SDA_GUARD_BIT];

	// Read view of bus_control_two; bits 7 and 6 are outside this block and read 0.
	always_comb begin
		bc2_view = 8'h00;
		bc2_view[ILCB_SDA_LEVEL_BIT] = sda_level;
		bc2_view[ILCB_SDA_GUARD_BIT] = 1'b1;
		bc2_view[ILCB_SCL_MON_BIT] = scl_level;
		bc2_view[ILCB_RSVD2_BIT] = 1'b1;
		bc2_view[ILCB_PART_RST_BIT] = part_rst;
		bc2_view[ILCB_RSVD0_BIT] = 1'b1;
	end

	// Read data selection.
	assign next_prdata = hit_bc2 ? {24'h000000, bc2_view} :
		hit_scl ? {31'h00000000, scl_run} : 32'h00000000;

	// Register writes; an unguarded write alone moves the SDA level.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sda_level <= ILCB_SDA_LEVEL_RST;
			part_rst <= ILCB_PART_RST_RST;
			scl_run <= 1'b0;
		end else begin
			if (sda_wr_ok) sda_level <= pwdata_i[ILCB_SDA_LEVEL_BIT];
			if (wr_acc && hit_bc2) part_rst <= pwdata_i[ILCB_PART_RST_BIT];
			if (wr_acc && hit_scl) scl_run <= pwdata_i[0];
		end
	end

	// Bus answer registers, loaded in setup so they stand through the access phase.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel_i && !penable_i) begin
			prdata <= pwrite_i ? 32'h00000000 : next_prdata;
			pslverr <= !(hit_bc2 || hit_scl);
		end else if (!acc) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
	end

	// Control logic; registers above live outside its reset.
	ilcb_ctrl u_ctrl (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.part_rst_i(part_rst),
		.scl_run_i(scl_run),
		.scl_level_o(scl_level),
		.state_o(ctrl_state)
	);

	// Pin drivers; open drain, enable high while pulling low.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sda_pin <= '{out: 1'b0, oe: 1'b0};
			scl_pin <= '{out: 1'b0, oe: 1'b0};
		end else begin
			sda_pin <= '{out: 1'b0, oe: !next_sda_level()};
			scl_pin <= '{out: 1'b0, oe: !scl_level};
		end
	end

	// Level that the SDA register will hold after this edge.
	function automatic logic next_sda_level();
		return sda_wr_ok ? pwdata_i[ILCB_SDA_LEVEL_BIT] : sda_level;
	endfunction : next_sda_level

	// Ready is asserted in every access phase: zero wait states.
	assign pready_o = 1'b1;
	assign prdata_o = prdata;
	assign pslverr_o = pslverr;
	assign sda_o = sda_pin.out;
	assign sda_oe_o = sda_pin.oe;
	assign scl_o = scl_pin.out;
	assign scl_oe_o = scl_pin.oe;

	// Checks.
	chk_sda_drive_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		sda_wr_ok && !pwdata_i[ILCB_SDA_LEVEL_BIT] |=> sda_oe_o && !sda_o)
		else $error("SDA not driven low after write of 0");
	chk_sda_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		sda_wr_ok && pwdata_i[ILCB_SDA_LEVEL_BIT] |=> !sda_oe_o)
		else $error("SDA not released after write of 1");
	chk_guard_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_acc && hit_bc2 && pwdata_i[ILCB_SDA_GUARD_BIT] |=> $stable(sda_level))
		else $error("Guarded write changed SDA level");
	chk_sda_readback: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_acc && hit_bc2 |-> prdata_o[ILCB_SDA_LEVEL_BIT] == !sda_oe_o)
		else $error("SDA level readback differs from pin drive");
	chk_fixed_ones: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_acc && hit_bc2 |-> prdata_o[ILCB_SDA_GUARD_BIT] && prdata_o[ILCB_RSVD2_BIT]
		&& prdata_o[ILCB_RSVD0_BIT])
		else $error("Fixed bits did not read 1");
	chk_scl_monitor: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_acc && hit_bc2 |-> prdata_o[ILCB_SCL_MON_BIT] == !scl_oe_o)
		else $error("SCL monitor differs from SCL output");
	chk_part_reset_held: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		part_rst |=> ctrl_state == ILCB_HELD && scl_level)
		else $error("Control logic ran during part reset");
	chk_regs_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		part_rst && !sda_wr_ok && !(wr_acc && hit_scl) |=> $stable(sda_level)
		&& $stable(scl_run))
		else $error("Part reset disturbed register contents");
endmodule : ilcb_line_ctrl
`default_nettype wire

//--- ilcb_bus_peer.sv
`timescale 1ns/1ps
`default_nettype none
// Other devices on the wire: both lines have pull-ups; the controller may pull either low, the peer only SDA.
module ilcb_bus_peer (
	input wire logic sda_oe_i,
	input wire logic scl_oe_i,
	input wire logic hold_sda_i,
	output logic sda_line_o,
	output logic scl_line_o
);
	// Wired-and of all drivers; released lines float high.
	assign sda_line_o = !(sda_oe_i || hold_sda_i);
	assign scl_line_o = !scl_oe_i;
endmodule : ilcb_bus_peer
`default_nettype wire

//--- test_i2c_line_control_bits.sv
`timescale 1ns/1ps
`default_nettype none
module test_i2c_line_control_bits;
	import ilcb_pkg::*;
	logic clk_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0, hold = 0;
	logic [7:0] pa = 8'h00;
	logic [31:0] pwd = 32'h0, prd, q;
	logic prdy, perr, serr, sda_o, sda_oe, scl_o, scl_oe, sda, scl, lvl, prt;
	logic [31:0] x = 32'hc66e;
	int fails = 0, n_checks = 0, i;
	ilcb_line_ctrl dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
		.pslverr_o(perr), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .scl_i(scl),
		.scl_o(scl_o), .scl_oe_o(scl_oe));
	ilcb_bus_peer peer (.sda_oe_i(sda_oe), .scl_oe_i(scl_oe), .hold_sda_i(hold),
		.sda_line_o(sda), .scl_line_o(scl));
	// Clock of 10 ns period.
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	function automatic logic [31:0] nxt();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : nxt
	// Expected readback of the control word.
	function automatic logic [31:0] ev(logic l, logic r, logic s);
		return {24'h0, 2'b00, l, 1'b1, s, 1'b1, r, 1'b1};
	endfunction : ev
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One APB transfer; answer taken in the access cycle that ends it, then an idle edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic rdy;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk_i);
		pen <= 1'b1;
		do begin
			@(negedge clk_i);
			rdy = prdy;
			serr = perr;
			q = prd;
			@(posedge clk_i);
		end while (rdy !== 1'b1);
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk_i);
	endtask : apb
	task automatic wait_scl(input logic v);
		for (int k = 0; k < 300 && scl_oe !== v; k++) @(posedge clk_i);
		chk({31'h0, scl_oe}, {31'h0, v});
	endtask : wait_scl
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	// Watchdog against a hung handshake.
	initial begin
		#100us;
		fails++;
		end_sim();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		lvl = 1'b1;
		prt = 1'b0;
		apb(0, ILCB_BUS_CONTROL_TWO_ADDR, 0);
		chk(q, ev(1, 0, 1));
		chk({30'h0, serr, sda_o}, 32'h0);
		// Random words, guard and reserved bits included, SCL idle.
		for (i = 0; i < 40; i++) begin
			void'(nxt());
			apb(1, ILCB_BUS_CONTROL_TWO_ADDR, x);
			if (!x[4]) lvl = x[5];
			prt = x[1];
			apb(0, ILCB_BUS_CONTROL_TWO_ADDR, 0);
			chk(q, ev(lvl, prt, 1));
			chk({sda_oe, sda}, {~lvl, lvl});
		end
		apb(1, ILCB_BUS_CONTROL_TWO_ADDR, 32'h20);
		lvl = 1'b1;
		chk({30'h0, sda_oe, scl_o}, 32'h0);
		// Run SCL, then read the monitor while it is low.
		apb(1, ILCB_SCL_CONTROL_ADDR, 32'h1);
		wait_scl(1);
		apb(0, ILCB_BUS_CONTROL_TWO_ADDR, 0);
		chk(q, ev(lvl, 0, 0));
		// A peer hangs SDA; part reset releases SCL, drive bit kept.
		hold <= 1'b1;
		apb(1, ILCB_BUS_CONTROL_TWO_ADDR, 32'h12);
		wait_scl(0);
		repeat (120) @(posedge clk_i);
		chk({31'h0, scl_oe}, 32'h0);
		apb(0, ILCB_BUS_CONTROL_TWO_ADDR, 0);
		chk(q, ev(lvl, 1, 1));
		hold <= 1'b0;
		apb(1, ILCB_BUS_CONTROL_TWO_ADDR, 32'h10);
		wait_scl(1);
		// Unmapped address: refused, reads zero.
		apb(1, 8'h08, 32'hff);
		chk({31'h0, serr}, 32'h1);
		apb(0, 8'h08, 0);
		chk(q, 32'h0);
		end_sim();
	end
endmodule : test_i2c_line_control_bits
`default_nettype wire
